/* File: rtl/ilssp_pkg.sv */
/*
  Shared constants for the light sensor two-wire port: slave address,
  command codes, result layout and timing counts.
  Assumes a 40 MHz system clock on both ends.
*/
`default_nettype none
package ilssp_pkg;
  localparam int          CLK_HZ         = 40_000_000;
  // Bus rate the master generates; standard mode keeps all margins
  localparam int          SCL_HZ         = 100_000;
  localparam int          SCL_QTR_CYCLES = CLK_HZ / (SCL_HZ * 4);
  // Continuous-mode integration period
  localparam int          INTEG_TIME_MS  = 100;
  localparam int          INTEG_CYCLES   = (CLK_HZ / 1000) * INTEG_TIME_MS;
  localparam logic [6:0]  SLAVE_ADDR     = 7'h29;
  localparam logic [7:0]  CMD_RESET      = 8'h80;
  localparam logic [7:0]  CMD_CONT       = 8'h0C;
  localparam logic [7:0]  CMD_ONCE       = 8'h04;
  localparam logic [7:0]  CMD_START      = 8'h08;
  localparam logic [7:0]  CMD_STOP       = 8'h30;
  localparam int          CMD_SHUT_BIT   = 7;
  localparam int          COUNT_W        = 15;
  localparam int          VALID_BIT      = 15;
  localparam logic [14:0] COUNT_MAX      = 15'h7FFF;
  // Host transaction kinds
  typedef enum logic [1:0] {
    ILSSP_SEND      = 2'b00,
    ILSSP_RECV_BYTE = 2'b01,
    ILSSP_RECV_WORD = 2'b10
  } ilssp_kind_t;
endpackage
`default_nettype wire

/* File: rtl/ilssp_if.sv */
/*
  Two-wire bus between the master end and the sensor end.
  Both lines are open drain: an enable high pulls the wire low,
  otherwise the pull-up holds it high.
*/
`timescale 1ns/1ps
`default_nettype none
interface ilssp_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Wired-AND with the pull-up: SCL of the master driver only, SDA of both drivers
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport sensor (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

/* File: rtl/ilssp_sensor.sv */
/*
  Sensor end of the two-wire port: slave decoder, command register,
  integration counter and result register.
  Assumes SCL and SDA arrive asynchronously and far slower than clock;
  light_pulse is the asynchronous converter pulse train.
*/
// Notes on behaviour
// - Eight-bit command register, writable; readable only while its top bit is set (shut-down)
// - Two-byte result register, never written by bus
// - Answer only slave address 0x29, MSB first
// - Send Byte writes exactly one command byte
// - Receive Byte returns exactly one byte
// - Receive Word returns two result bytes; in shut-down the command replaces the low byte
// - Master writes start, address, direction low
// - Acknowledge own address in the ack slot
// - Eight data bits MSB first, then acknowledge
// - Master ends write with stop
// - Master reads with start, address, direction high
// - Drive eight read bits MSB first
// - Master NACKs single byte, then stops
// - Word read: two bytes, NACK, stop
// - Result is 15-bit count plus valid
// - Fifteen-bit counter accumulates pulse train
// - Valid at bit 15, count below
// - Top bit set means shut-down; stored unchanged
// - 0x0C continuous, 0x04 single integration
// - 0x08 clears and starts, 0x30 stops, valid
`timescale 1ns/1ps
`default_nettype none
module ilssp_sensor #(
  parameter int INTEG_CYCLES = ilssp_pkg::INTEG_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  ilssp_if.sensor          bus,
  input  wire logic        light_pulse,
  output logic [7:0]       command_out,
  output logic [15:0]      result_out
);
  typedef enum logic [2:0] {
    ILSSP_S_IDLE  = 3'b000,
    ILSSP_S_ADDR  = 3'b001,
    ILSSP_S_ACK_A = 3'b010,
    ILSSP_S_WR    = 3'b011,
    ILSSP_S_ACK_W = 3'b100,
    ILSSP_S_RD    = 3'b101,
    ILSSP_S_ACK_M = 3'b110,
    ILSSP_S_IGN   = 3'b111
  } ilssp_sst_t;

  typedef enum logic [1:0] {
    ILSSP_M_SHUT = 2'b00,
    ILSSP_M_CONT = 2'b01,
    ILSSP_M_ONCE = 2'b10
  } ilssp_mode_t;

  typedef struct packed {
    logic [2:0]  scl_y;      // [0] first stage, [1] second, [2] previous
    logic [2:0]  sda_y;
    logic [2:0]  lp_y;
    ilssp_sst_t  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic        rw;
    logic        bsel;
    logic        mack;
    logic [15:0] snap;
    logic        sda_oe;
    logic [7:0]  cmd;
    ilssp_mode_t mode;
    logic        integ;
    logic [14:0] acc;
    logic [31:0] tmr;
    logic [14:0] count;
    logic        valid;
  } ilssp_sens_t;

  ilssp_sens_t q;
  ilssp_sens_t d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        lp_rise;
  logic [15:0] word;

  // Edges only from synchronised stages, never from the first flop
  assign scl_rise = q.scl_y[1] && !q.scl_y[2];
  assign scl_fall = !q.scl_y[1] && q.scl_y[2];
  assign start_c  = q.scl_y[1] && q.scl_y[2] && !q.sda_y[1] && q.sda_y[2];
  assign stop_c   = q.scl_y[1] && q.scl_y[2] && q.sda_y[1] && !q.sda_y[2];
  assign lp_rise  = q.lp_y[1] && !q.lp_y[2];
  assign word     = {q.valid, q.count};

  // Next state of the whole sensor
  always_comb begin
    d = q;
    d.scl_y = {q.scl_y[1:0], bus.scl};
    d.sda_y = {q.sda_y[1:0], bus.sda};
    d.lp_y  = {q.lp_y[1:0], light_pulse};

    if (lp_rise && ((q.mode == ILSSP_M_CONT) || q.integ) &&
        (q.acc != ilssp_pkg::COUNT_MAX)) begin
      d.acc = q.acc + 15'h0001;
    end
    if (q.mode == ILSSP_M_CONT) begin
      if (q.tmr >= 32'(INTEG_CYCLES - 1)) begin
        d.tmr   = 32'h00000000;
        d.count = q.acc;
        d.valid = 1'b1;
        d.acc   = 15'h0000;
      end else begin
        d.tmr = q.tmr + 32'h00000001;
      end
    end

    // Bus sampling on SCL rise
    if (scl_rise) begin
      unique case (q.st)
        ILSSP_S_ADDR, ILSSP_S_WR: begin
          d.sh  = {q.sh[6:0], q.sda_y[1]};
          d.cnt = q.cnt + 4'h1;
        end
        ILSSP_S_ACK_M: d.mack = !q.sda_y[1];
        default: ;
      endcase
    end

    // Bus driving on SCL fall; SDA only changes while SCL is low
    if (scl_fall) begin
      unique case (q.st)
        ILSSP_S_ADDR: begin
          if (q.cnt == 4'h8) begin
            if (q.sh[7:1] == ilssp_pkg::SLAVE_ADDR) begin
              d.st     = ILSSP_S_ACK_A;
              d.sda_oe = 1'b1;
              d.rw     = q.sh[0];
              d.snap   = word;
            end else begin
              d.st = ILSSP_S_IGN;
            end
          end
        end
        ILSSP_S_ACK_A: begin
          d.cnt  = 4'h0;
          d.bsel = 1'b0;
          if (q.rw) begin
            d.tx     = q.cmd[ilssp_pkg::CMD_SHUT_BIT] ? q.cmd : q.snap[7:0];
            d.sda_oe = q.cmd[ilssp_pkg::CMD_SHUT_BIT] ? !q.cmd[7]
                                                      : !q.snap[7];
            d.st     = ILSSP_S_RD;
          end else begin
            d.sda_oe = 1'b0;
            d.st     = ILSSP_S_WR;
          end
        end
        ILSSP_S_WR: begin
          if (q.cnt == 4'h8) begin
            d.cmd    = q.sh;
            d.st     = ILSSP_S_ACK_W;
            d.sda_oe = 1'b1;
            if (q.sh[ilssp_pkg::CMD_SHUT_BIT]) begin
              d.mode  = ILSSP_M_SHUT;
              d.integ = 1'b0;
            end else if (q.sh == ilssp_pkg::CMD_CONT) begin
              d.mode  = ILSSP_M_CONT;
              d.integ = 1'b0;
              d.valid = d.valid && (d.tmr == 32'h00000000) &&
                        (q.mode == ILSSP_M_CONT);
              d.acc   = 15'h0000;
              d.tmr   = 32'h00000000;
            end else if (q.sh == ilssp_pkg::CMD_ONCE) begin
              d.mode  = ILSSP_M_ONCE;
              d.integ = 1'b0;
            end else if (q.sh == ilssp_pkg::CMD_START &&
                         q.mode == ILSSP_M_ONCE) begin
              d.count = 15'h0000;
              d.valid = 1'b0;
              d.acc   = 15'h0000;
              d.integ = 1'b1;
            end else if (q.sh == ilssp_pkg::CMD_STOP &&
                         q.mode == ILSSP_M_ONCE) begin
              d.count = q.acc;
              d.valid = 1'b1;
              d.integ = 1'b0;
            end
          end
        end
        ILSSP_S_ACK_W: begin
          d.sda_oe = 1'b0;
          d.st     = ILSSP_S_IGN;
        end
        ILSSP_S_RD: begin
          if (q.cnt == 4'h7) begin
            d.sda_oe = 1'b0;
            d.st     = ILSSP_S_ACK_M;
          end else begin
            d.tx     = {q.tx[6:0], 1'b0};
            d.sda_oe = !q.tx[6];
            d.cnt    = q.cnt + 4'h1;
          end
        end
        ILSSP_S_ACK_M: begin
          if (q.mack && !q.bsel) begin
            d.bsel   = 1'b1;
            d.cnt    = 4'h0;
            d.tx     = q.snap[15:8];
            d.sda_oe = !q.snap[15];
            d.st     = ILSSP_S_RD;
          end else begin
            d.st = ILSSP_S_IGN;
          end
        end
        default: ;
      endcase
    end

    // Start and stop override any transfer in progress
    if (start_c) begin
      d.st     = ILSSP_S_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st     = ILSSP_S_IDLE;
      d.sda_oe = 1'b0;
    end
  end

  // Single state register; lines idle high after reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.scl_y <= 3'h7;
      q.sda_y <= 3'h7;
      q.st    <= ILSSP_S_IDLE;
      q.cmd   <= ilssp_pkg::CMD_RESET;
      q.mode  <= ILSSP_M_SHUT;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = q.sda_oe;
  assign command_out  = q.cmd;
  assign result_out   = word;
endmodule
`default_nettype wire

/* File: rtl/ilssp_master.sv */
/*
  Master end of the two-wire port: runs Send Byte, Receive Byte and
  Receive Word on a one-cycle request, making SCL from the clock.
  Assumes the slave never stretches the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ilssp_master #(
  parameter int QTR_CYCLES = ilssp_pkg::SCL_QTR_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               reset,
  ilssp_if.master                 bus,
  input  wire logic               req,
  input  wire logic [1:0]         kind,
  input  wire logic [7:0]         wr_data,
  output logic [15:0]             rd_data,
  output logic                    done,
  output logic                    nack,
  output logic                    busy
);
  typedef enum logic [1:0] {
    ILSSP_H_IDLE  = 2'b00,
    ILSSP_H_START = 2'b01,
    ILSSP_H_BIT   = 2'b10,
    ILSSP_H_STOP  = 2'b11
  } ilssp_hst_t;

  typedef struct packed {
    logic [1:0]  sda_y;
    ilssp_hst_t  st;
    logic [15:0] tmr;
    logic [1:0]  qc;
    logic [3:0]  bi;
    logic [1:0]  b;
    logic [7:0]  sh;
    logic [1:0]  kind;
    logic [7:0]  wr;
    logic [15:0] rd;
    logic        scl_oe;
    logic        sda_oe;
    logic        done;
    logic        nack;
    logic        busy;
  } ilssp_mast_t;

  ilssp_mast_t q;
  ilssp_mast_t d;
  logic        tick;
  logic        reading;
  logic        more;

  // Quarter-bit enable from the divider
  assign tick    = q.st != ILSSP_H_IDLE && q.tmr == 16'(QTR_CYCLES - 1);
  assign reading = q.b != 2'h0 && q.kind != ilssp_pkg::ILSSP_SEND;
  assign more    = q.kind == ilssp_pkg::ILSSP_RECV_WORD && q.b == 2'h1;

  // Next state of the whole master
  always_comb begin
    d       = q;
    d.sda_y = {q.sda_y[0], bus.sda};
    d.done  = 1'b0;
    d.tmr   = (q.st == ILSSP_H_IDLE || tick) ? 16'h0000 : q.tmr + 16'h0001;
    if (q.st != ILSSP_H_IDLE && tick) begin
      d.qc = q.qc + 2'h1;
    end
    unique case (q.st)
      ILSSP_H_IDLE: begin
        if (req) begin
          d.sh   = {ilssp_pkg::SLAVE_ADDR, kind != ilssp_pkg::ILSSP_SEND};
          d.kind = kind;
          d.wr   = wr_data;
          d.b    = 2'h0;
          d.bi   = 4'h0;
          d.qc   = 2'h0;
          d.nack = 1'b0;
          d.busy = 1'b1;
          d.st   = ILSSP_H_START;
        end
      end
      ILSSP_H_START: begin
        if (tick) begin
          unique case (q.qc)
            2'h1: d.sda_oe = 1'b1;    // SDA falls with SCL high
            2'h3: begin
              d.scl_oe = 1'b1;
              d.st     = ILSSP_H_BIT;
            end
            default: ;
          endcase
        end
      end
      ILSSP_H_BIT: begin
        if (tick) begin
          unique case (q.qc)
            2'h0: d.scl_oe = 1'b1;
            // Data changes a quarter after SCL falls
            2'h1: begin
              if (q.bi == 4'h8) begin
                d.sda_oe = reading && more;
              end else begin
                d.sda_oe = !reading && !q.sh[7];
              end
            end
            2'h2: d.scl_oe = 1'b0;
            2'h3: begin
              if (q.bi != 4'h8) begin
                d.sh = {q.sh[6:0], q.sda_y[1]};
                d.bi = q.bi + 4'h1;
              end else begin
                d.bi = 4'h0;
                d.b  = q.b + 2'h1;
                if (reading) begin
                  if (q.b == 2'h1) d.rd[7:0] = q.sh;
                  else d.rd[15:8] = q.sh;
                  if (!more) d.st = ILSSP_H_STOP;
                end else if (q.sda_y[1]) begin
                  d.nack = 1'b1;
                  d.st   = ILSSP_H_STOP;
                end else if (q.b == 2'h0 &&
                             q.kind == ilssp_pkg::ILSSP_SEND) begin
                  d.sh = q.wr;
                end else if (q.b != 2'h0) begin
                  d.st = ILSSP_H_STOP;
                end
              end
            end
            default: ;
          endcase
        end
      end
      ILSSP_H_STOP: begin
        if (tick) begin
          unique case (q.qc)
            2'h0: d.scl_oe = 1'b1;
            2'h1: d.sda_oe = 1'b1;
            2'h2: d.scl_oe = 1'b0;
            2'h3: begin
              d.sda_oe = 1'b0;    // SDA rises with SCL high
              d.done   = 1'b1;
              d.busy   = 1'b0;
              d.st     = ILSSP_H_IDLE;
            end
            default: ;
          endcase
        end
      end
      default: ;
    endcase
  end

  // Single state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.sda_y <= 2'h3;
      q.st    <= ILSSP_H_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = q.scl_oe;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = q.sda_oe;
  assign rd_data      = q.rd;
  assign done         = q.done;
  assign nack         = q.nack;
  assign busy         = q.busy;
endmodule
`default_nettype wire

/* File: verification/ilssp_assertions.sv */
/*
  Wire-level checks for the two-wire link between master and sensor ends.
  Assumes it watches the resolved lines and the drivers' enables of one
  interface, all in the clock domain of both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module ilssp_assertions #(
  parameter int QTR_CYCLES = 10
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_p;
  logic       sda_p;
  logic [4:0] cnt;
  logic [7:0] adr;
  logic [9:0] lo_c;
  logic [9:0] hi_c;
  logic       rise;
  logic       start_w;
  logic       own;

  // Bus events decoded from one-cycle-old line levels
  assign rise    = scl && !scl_p;
  assign start_w = scl && scl_p && sda_p && !sda;
  assign own     = (adr[7:1] == ilssp_pkg::SLAVE_ADDR);

  // Count SCL rises since start and collect the address byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      cnt   <= 5'h1F;
      adr   <= 8'h00;
      lo_c  <= 10'h000;
      hi_c  <= 10'h000;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (start_w) begin
        cnt <= 5'h00;
      end else if (rise && cnt != 5'h1F) begin
        cnt <= cnt + 5'h01;
        if (cnt < 5'h08) begin
          adr <= {adr[6:0], sda};
        end
      end
      // Saturating run lengths of the master's SCL pull
      lo_c <= !scl_m_oe ? 10'h000 : (lo_c == 10'h3FF ? lo_c : lo_c + 10'h001);
      hi_c <= scl_m_oe ? 10'h000 : (hi_c == 10'h3FF ? hi_c : hi_c + 10'h001);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_reset_lines_free: assert property ($fell(reset) |->
    !scl_m_oe && !sda_m_oe && !sda_s_oe) else $error("line driven at reset");
  chk_addr_ack_low: assert property (rise && cnt == 5'h08 && own |->
    !sda) else $error("own address not acknowledged");
  chk_data_ack_low: assert property (
    rise && cnt == 5'h11 && own && !adr[0] |-> !sda)
    else $error("write byte not acknowledged");
  chk_read_bits_end: assert property (
    rise && (cnt == 5'h11 || cnt == 5'h1A) && adr[0] |-> !sda_s_oe)
    else $error("sensor drives master ack slot");
  chk_write_no_drive: assert property (
    scl && !rise && cnt >= 5'h0A && cnt <= 5'h11 && !adr[0] |-> !sda_s_oe)
    else $error("sensor drives during write data");
  chk_ack_hold: assert property ($rose(sda_s_oe) |-> sda_s_oe[*8])
    else $error("sensor pull too short");
  chk_drive_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("sensor changes data while clock high");
  chk_scl_low_time: assert property (
    $fell(scl_m_oe) |-> int'(lo_c) >= 2 * QTR_CYCLES)
    else $error("clock low period short");
  chk_scl_high_time: assert property (
    $rose(scl_m_oe) |-> int'(hi_c) >= 2 * QTR_CYCLES)
    else $error("clock high period short");
  chk_start_hold: assert property (start_w |-> scl[*8])
    else $error("clock falls too soon after start");

  cover property (rise && cnt == 5'h08 && adr[0]);
endmodule
`default_nettype wire

/* File: verification/ilssp_tb.sv */
/*
  Bench for the two-wire light sensor port: master end against sensor end,
  plus a hand-driven second bus for foreign-address traffic.
  Assumes the rtl package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ilssp_tb;
  localparam int Q     = 10;
  localparam int BQ    = 2;
  localparam int INTEG = 5000;
  logic        clock      = 1'b0;
  logic        reset      = 1'b1;
  logic        req        = 1'b0;
  logic [1:0]  kind       = 2'b00;
  logic [7:0]  wr_data    = 8'h00;
  logic        light      = 1'b0;
  logic [7:0]  cmd_a;
  logic [7:0]  cmd_b;
  logic [15:0] res_a;
  logic [15:0] rd_data;
  logic        done;
  logic        nack;
  logic        busy;
  logic [1:0]  ack;
  int          fail_count = 0;
  int          num_checks = 0;

  ilssp_if bus_a ();
  ilssp_if bus_b ();

  ilssp_master #(.QTR_CYCLES(Q)) ilssp_master_inst (.clock(clock),
    .reset(reset), .bus(bus_a), .req(req), .kind(kind), .wr_data(wr_data),
    .rd_data(rd_data), .done(done), .nack(nack), .busy(busy));
  ilssp_sensor #(.INTEG_CYCLES(INTEG)) ilssp_sensor_inst (.clock(clock),
    .reset(reset), .bus(bus_a), .light_pulse(light), .command_out(cmd_a),
    .result_out(res_a));
  // Second sensor faces the bench's own bit-banged master
  ilssp_sensor #(.INTEG_CYCLES(INTEG)) ilssp_sensor_inst_2 (.clock(clock),
    .reset(reset), .bus(bus_b), .light_pulse(1'b0), .command_out(cmd_b),
    .result_out());
  ilssp_assertions #(.QTR_CYCLES(Q)) ilssp_assertions_inst (.clock(clock),
    .reset(reset), .scl_m_oe(bus_a.scl_m_oe), .sda_m_oe(bus_a.sda_m_oe),
    .sda_s_oe(bus_a.sda_s_oe), .scl(bus_a.scl), .sda(bus_a.sda));

  // 40 MHz clock
  always #12.5 clock = ~clock;

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // One request pulse, then a bounded wait for done; slave must ack
  task automatic xfer(input logic [1:0] k, input logic [7:0] d);
    @(negedge clock);
    req     = 1'b1;
    kind    = k;
    wr_data = d;
    @(negedge clock);
    req = 1'b0;
    check({15'h0000, busy}, 16'h0001, "busy not raised");
    for (int i = 0; i < 3000; i++) begin
      @(negedge clock);
      if (done === 1'b1) break;
    end
    // A limit that runs out leaves done low and counts as a mismatch
    check({15'h0000, done}, 16'h0001, "transfer timed out");
    check({15'h0000, busy}, 16'h0000, "busy after done");
    check({15'h0000, nack}, 16'h0000, "not acknowledged");
  endtask

  // Converter pulses, four clocks high and four low
  task automatic pulses(input int n);
    repeat (n) begin
      light = 1'b1;
      repeat (4) @(negedge clock);
      light = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask

  // Quarter of the bench-made link clock: 200 ns a bit
  task automatic wq();
    repeat (BQ) @(negedge clock);
  endtask

  task automatic bb_bit(input logic b, output logic r);
    bus_b.sda_m_oe = ~b;
    wq();
    bus_b.scl_m_oe = 1'b0;
    wq();
    r = bus_b.sda;
    wq();
    bus_b.scl_m_oe = 1'b1;
    wq();
  endtask

  // Start, address byte, data byte, stop; ack slots released by us
  task automatic bb_write(input logic [7:0] a, input logic [7:0] d);
    logic        r;
    logic [15:0] v;
    v = {a, d};
    bus_b.sda_m_oe = 1'b1;
    wq();
    wq();
    bus_b.scl_m_oe = 1'b1;
    wq();
    for (int i = 0; i < 18; i++) begin
      bb_bit((i == 8 || i == 17) ? 1'b1 : v[15 - i + int'(i > 8)], r);
      if (i == 8) ack[1] = r;
      if (i == 17) ack[0] = r;
    end
    bus_b.sda_m_oe = 1'b1;
    wq();
    bus_b.scl_m_oe = 1'b0;
    wq();
    bus_b.sda_m_oe = 1'b0;
    wq();
  endtask

  task automatic t_reset();
    check({8'h00, cmd_a}, 16'h0080, "command reset value"); // default
    check(res_a, 16'h0000, "result reset value"); // reset
    $display("test reset done");
  endtask

  task automatic t_byte();
    xfer(ilssp_pkg::ILSSP_SEND, 8'h9C); // send
    check({8'h00, cmd_a}, 16'h009C, "command not stored"); // write
    xfer(ilssp_pkg::ILSSP_RECV_BYTE, 8'h00); // read
    check({8'h00, rd_data[7:0]}, 16'h009C, "readback"); // readback
    $display("test byte done");
  endtask

  task automatic t_cont();
    xfer(ilssp_pkg::ILSSP_SEND, 8'h0C); // continuous
    xfer(ilssp_pkg::ILSSP_RECV_WORD, 8'h00); // word read
    check({15'h0000, rd_data[15]}, 16'h0000, "valid too early"); // mode
    // Five pulses land well inside the first period
    pulses(5); // counted
    repeat (INTEG) @(negedge clock);
    xfer(ilssp_pkg::ILSSP_RECV_WORD, 8'h00); // word read
    check(rd_data, 16'h8005, "period result"); // refresh
    xfer(ilssp_pkg::ILSSP_SEND, 8'h08); // ignored
    xfer(ilssp_pkg::ILSSP_RECV_WORD, 8'h00); // word read
    check(rd_data, 16'h8005, "start honoured"); // ignored
    $display("test continuous done");
  endtask

  task automatic t_single();
    xfer(ilssp_pkg::ILSSP_SEND, 8'h04); // single mode
    xfer(ilssp_pkg::ILSSP_SEND, 8'h08); // start
    check(res_a, 16'h0000, "start did not clear"); // clear
    pulses(10); // counted
    xfer(ilssp_pkg::ILSSP_SEND, 8'h30); // stop
    pulses(3); // not counted
    xfer(ilssp_pkg::ILSSP_RECV_WORD, 8'h00); // word read
    check(rd_data, 16'h800A, "word read"); // word
    check(res_a, 16'h800A, "result layout"); // layout
    $display("test single done");
  endtask

  task automatic t_foreign();
    bb_write(8'h54, 8'h85); // foreign
    check({14'h0000, ack}, 16'h0003, "foreign acked"); // no ack
    check({8'h00, cmd_b}, 16'h0080, "foreign write"); // ignored
    bb_write(8'h52, 8'h1D); // own
    check({14'h0000, ack}, 16'h0000, "own not acked"); // ack
    check({8'h00, cmd_b}, 16'h001D, "own write lost"); // stored
    $display("test foreign done");
  endtask

  // Main sequence; the second bus starts released
  initial begin
    bus_b.scl_m_o  = 1'b0;
    bus_b.sda_m_o  = 1'b0;
    bus_b.scl_m_oe = 1'b0;
    bus_b.sda_m_oe = 1'b0;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    t_reset();
    t_byte();
    t_cont();
    t_single();
    t_foreign();
    end_of_test();
  end

  // Watchdog: the full run needs about 16,000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
